// >>> tap_regs.vh
`ifndef TAP_REGS_VH
`define TAP_REGS_VH

// TAP controller state codes (standard 16-state sequence)
`define TAP_ST_RESET      4'h0
`define TAP_ST_IDLE       4'h1
`define TAP_ST_SEL_DR     4'h2
`define TAP_ST_CAP_DR     4'h3
`define TAP_ST_SHIFT_DR   4'h4
`define TAP_ST_EXIT1_DR   4'h5
`define TAP_ST_PAUSE_DR   4'h6
`define TAP_ST_EXIT2_DR   4'h7
`define TAP_ST_UPD_DR     4'h8
`define TAP_ST_SEL_IR     4'h9
`define TAP_ST_CAP_IR     4'ha
`define TAP_ST_SHIFT_IR   4'hb
`define TAP_ST_EXIT1_IR   4'hc
`define TAP_ST_PAUSE_IR   4'hd
`define TAP_ST_EXIT2_IR   4'he
`define TAP_ST_UPD_IR     4'hf

// Instruction register width and captured pattern (low bits 01)
`define TAP_IR_WIDTH      4
`define TAP_IR_CAPTURE    4'h1
// Instruction loaded at controller reset (bypass, all ones)
`define TAP_IR_RESET      4'hf

// Fastest legal test clock, in kHz, and system clock in kHz
`define TAP_TCK_MAX_KHZ   10000
`define TAP_SYS_KHZ       100000

`endif

// >>> tap_sync.v
`timescale 1ns/10ps
`include "tap_regs.vh"

// Two-stage synchroniser for a bundle of pin inputs
module tap_sync #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             clk_sys,
    input  wire             resetn,
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] meta_r;   // First stage, read only by second stage
    reg [WIDTH-1:0] sync_r;   // Second stage, safe for logic

    // Sample the pins twice before anyone else looks at them
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            meta_r <= INIT;
            sync_r <= INIT;
        end
        else
        begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;

endmodule

// >>> tap_port.v
// Summary of operation
// - Test reset low forces controller reset after the pin synchroniser, without a test clock edge
// - Mode select on rising edge steps states
// - Serial input captured on rising test clock
// - Serial output changes only on falling edges
`timescale 1ns/10ps
`include "tap_regs.vh"

module tap_port #(
    parameter IR_W  = `TAP_IR_WIDTH,   // Instruction register width
    parameter DR_W  = 32               // General data register width
) (
    input  wire            clk_sys,
    input  wire            resetn,
    input  wire            test_port_reset_n,
    input  wire            test_port_clock,
    input  wire            test_port_mode_select,
    input  wire            test_port_serial_in,
    output reg             test_port_serial_out,
    output reg             test_port_serial_out_en,
    output reg  [3:0]      tap_state,
    output reg  [IR_W-1:0] tap_instr,
    output reg             tck_too_fast
);

    // Shortest legal test clock half period, in system cycles
    localparam integer HALF_CYC =
        `TAP_SYS_KHZ / (2 * `TAP_TCK_MAX_KHZ);

    wire [3:0] pins_s;          // Synchronised pin levels
    wire       trst_n_s;        // Test reset, synchronised
    wire       tck_s;           // Test clock, synchronised
    wire       tms_s;           // Mode select, synchronised
    wire       tdi_s;           // Serial input, synchronised

    reg        tck_d_r;         // Previous test clock level
    reg  [3:0] state_r;         // Controller state
    reg  [3:0] state_nxt;
    reg  [IR_W-1:0] ir_sh_r;    // Instruction shift stage
    reg  [IR_W-1:0] ir_r;       // Active instruction
    reg  [DR_W-1:0] dr_r;       // Data shift path
    reg        byp_r;           // One-bit bypass path
    reg  [7:0] hcnt_r;          // System cycles since last clock edge

    wire       tck_rise = tck_s & ~tck_d_r;
    wire       tck_fall = ~tck_s & tck_d_r;
    wire       bypass   = &ir_r;

    tap_sync #(
        .WIDTH (4),
        .INIT  (4'hb)
    ) u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .din     ({test_port_reset_n, test_port_clock,
                   test_port_mode_select, test_port_serial_in}),
        .dout    (pins_s)
    );

    assign trst_n_s = pins_s[3];
    assign tck_s    = pins_s[2];
    assign tms_s    = pins_s[1];
    assign tdi_s    = pins_s[0];

    // Is the state one where the serial output is live
    function is_shift;
        input [3:0] st;
        begin
            is_shift = (st == `TAP_ST_SHIFT_DR) || (st == `TAP_ST_SHIFT_IR);
        end
    endfunction

    // Standard next-state map, stepped by mode select
    always @*
    begin
        case (state_r)
            `TAP_ST_RESET:    state_nxt = tms_s ? `TAP_ST_RESET
                                                : `TAP_ST_IDLE;
            `TAP_ST_IDLE:     state_nxt = tms_s ? `TAP_ST_SEL_DR
                                                : `TAP_ST_IDLE;
            `TAP_ST_SEL_DR:   state_nxt = tms_s ? `TAP_ST_SEL_IR
                                                : `TAP_ST_CAP_DR;
            `TAP_ST_CAP_DR:   state_nxt = tms_s ? `TAP_ST_EXIT1_DR
                                                : `TAP_ST_SHIFT_DR;
            `TAP_ST_SHIFT_DR: state_nxt = tms_s ? `TAP_ST_EXIT1_DR
                                                : `TAP_ST_SHIFT_DR;
            `TAP_ST_EXIT1_DR: state_nxt = tms_s ? `TAP_ST_UPD_DR
                                                : `TAP_ST_PAUSE_DR;
            `TAP_ST_PAUSE_DR: state_nxt = tms_s ? `TAP_ST_EXIT2_DR
                                                : `TAP_ST_PAUSE_DR;
            `TAP_ST_EXIT2_DR: state_nxt = tms_s ? `TAP_ST_UPD_DR
                                                : `TAP_ST_SHIFT_DR;
            `TAP_ST_UPD_DR:   state_nxt = tms_s ? `TAP_ST_SEL_DR
                                                : `TAP_ST_IDLE;
            `TAP_ST_SEL_IR:   state_nxt = tms_s ? `TAP_ST_RESET
                                                : `TAP_ST_CAP_IR;
            `TAP_ST_CAP_IR:   state_nxt = tms_s ? `TAP_ST_EXIT1_IR
                                                : `TAP_ST_SHIFT_IR;
            `TAP_ST_SHIFT_IR: state_nxt = tms_s ? `TAP_ST_EXIT1_IR
                                                : `TAP_ST_SHIFT_IR;
            `TAP_ST_EXIT1_IR: state_nxt = tms_s ? `TAP_ST_UPD_IR
                                                : `TAP_ST_PAUSE_IR;
            `TAP_ST_PAUSE_IR: state_nxt = tms_s ? `TAP_ST_EXIT2_IR
                                                : `TAP_ST_PAUSE_IR;
            `TAP_ST_EXIT2_IR: state_nxt = tms_s ? `TAP_ST_UPD_IR
                                                : `TAP_ST_SHIFT_IR;
            `TAP_ST_UPD_IR:   state_nxt = tms_s ? `TAP_ST_SEL_DR
                                                : `TAP_ST_IDLE;
            default:          state_nxt = `TAP_ST_RESET;
        endcase
    end

    // Controller and shift paths advance on test clock rising edges
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            tck_d_r <= 1'b0;    // Idle-low clock, so no false edge
            state_r <= `TAP_ST_RESET;
            ir_sh_r <= `TAP_IR_RESET;
            ir_r    <= `TAP_IR_RESET;
            dr_r    <= {DR_W{1'b0}};
            byp_r   <= 1'b0;
        end
        else
        begin
            tck_d_r <= tck_s;
            // Test reset wins without waiting for a clock edge
            if (!trst_n_s)
            begin
                state_r <= `TAP_ST_RESET;
                ir_r    <= `TAP_IR_RESET;
            end
            else if (tck_rise)
            begin
                state_r <= state_nxt;
                case (state_r)
                    `TAP_ST_RESET:
                        ir_r <= `TAP_IR_RESET;
                    `TAP_ST_CAP_IR:
                        ir_sh_r <= `TAP_IR_CAPTURE;
                    `TAP_ST_SHIFT_IR:
                        ir_sh_r <= {tdi_s, ir_sh_r[IR_W-1:1]};
                    `TAP_ST_UPD_IR:
                        ir_r <= ir_sh_r;
                    `TAP_ST_CAP_DR:
                        byp_r <= 1'b0;
                    `TAP_ST_SHIFT_DR:
                    begin
                        // Bypass is one stage; other codes use the wide path
                        if (bypass)
                            byp_r <= tdi_s;
                        else
                            dr_r <= {tdi_s, dr_r[DR_W-1:1]};
                    end
                    default:
                        byp_r <= byp_r;
                endcase
            end
        end
    end

    // Serial output moves only on falling edges; its enable also drops on test reset
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            test_port_serial_out    <= 1'b0;
            test_port_serial_out_en <= 1'b0;
        end
        else if (!trst_n_s)
        begin
            test_port_serial_out_en <= 1'b0;
        end
        else if (tck_fall)
        begin
            test_port_serial_out_en <= is_shift(state_r);
            if (state_r == `TAP_ST_SHIFT_IR)
                test_port_serial_out <= ir_sh_r[0];
            else if (bypass)
                test_port_serial_out <= byp_r;
            else
                test_port_serial_out <= dr_r[0];
        end
    end

    // Flag a test clock running past its limit; sticky until reset.
    // Half period is measured between opposite edges in system cycles.
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            hcnt_r       <= 8'h00;
            tck_too_fast <= 1'b0;
        end
        else if (tck_rise || tck_fall)
        begin
            hcnt_r <= 8'h01;
            if (hcnt_r != 8'h00 && hcnt_r < HALF_CYC[7:0])
                tck_too_fast <= 1'b1;
        end
        else if (hcnt_r != 8'hff && hcnt_r != 8'h00)
        begin
            hcnt_r <= hcnt_r + 8'h01;
        end
    end

    // Mirror of controller state for observation
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            tap_state <= `TAP_ST_RESET;
            tap_instr <= `TAP_IR_RESET;
        end
        else
        begin
            tap_state <= state_r;
            tap_instr <= ir_r;
        end
    end

endmodule

// >>> tap_port_chk.sv
`timescale 1ns/10ps
`include "tap_regs.vh"
module tap_port_chk #(
    parameter IR_W = 4
) (
    input wire            clk_sys,
    input wire            resetn,
    input wire            test_port_reset_n,
    input wire            test_port_clock,
    input wire            test_port_mode_select,
    input wire            test_port_serial_in,
    input wire            test_port_serial_out,
    input wire            test_port_serial_out_en,
    input wire [3:0]      tap_state,
    input wire [IR_W-1:0] tap_instr,
    input wire            tck_too_fast
);
    reg       tck_r;  // Test clock pin one cycle ago
    reg [7:0] fall_r; // Cycles since a clock fall or test reset
    reg [7:0] rise_r; // Cycles since a clock rise or test reset
    // Ages saturate so a long idle gap never wraps into a match
    always @(posedge clk_sys)
    begin
        tck_r <= test_port_clock;
        fall_r <= (!resetn || !test_port_reset_n ||
                   (tck_r && !test_port_clock)) ? 8'h00 :
                  fall_r + {7'h00, fall_r != 8'hff};
        rise_r <= (!resetn || !test_port_reset_n ||
                   (!tck_r && test_port_clock)) ? 8'h00 :
                  rise_r + {7'h00, rise_r != 8'hff};
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Test reset held long enough to pass the pin synchroniser
    sequence trst_held;
        !test_port_reset_n [*5];
    endsequence
    // Output enable turning on
    sequence en_rising;
        !test_port_serial_out_en ##1 test_port_serial_out_en;
    endsequence
    trst_reset_a: assert property (trst_held |->
        tap_state == `TAP_ST_RESET && tap_instr == `TAP_IR_RESET
        && !test_port_serial_out_en)
        else $error("test reset left the controller running");
    state_step_a: assert property ($changed(tap_state) |->
        rise_r <= 8'd5)
        else $error("state moved without a test clock rise");
    // Mirrors lag together: an update shows the state that follows it
    instr_load_a: assert property ($changed(tap_instr) |->
        $past(tap_state) == `TAP_ST_UPD_IR || tap_state == `TAP_ST_RESET)
        else $error("instruction changed outside update or reset");
    out_fall_a: assert property ($changed(test_port_serial_out) |->
        fall_r <= 8'd5)
        else $error("serial out changed away from a falling edge");
    en_rise_a: assert property (en_rising |->
        tap_state inside {`TAP_ST_SHIFT_IR, `TAP_ST_SHIFT_DR})
        else $error("output enabled outside a shift state");
    en_hold_a: assert property (test_port_serial_out_en |->
        tap_state inside {`TAP_ST_SHIFT_IR, `TAP_ST_SHIFT_DR,
        `TAP_ST_EXIT1_IR, `TAP_ST_EXIT1_DR})
        else $error("output still driven after leaving shift");
endmodule
bind tap_port tap_port_chk #(.IR_W(IR_W)) chk (
    .clk_sys(clk_sys), .resetn(resetn),
    .test_port_reset_n(test_port_reset_n),
    .test_port_clock(test_port_clock),
    .test_port_mode_select(test_port_mode_select),
    .test_port_serial_in(test_port_serial_in),
    .test_port_serial_out(test_port_serial_out),
    .test_port_serial_out_en(test_port_serial_out_en),
    .tap_state(tap_state), .tap_instr(tap_instr),
    .tck_too_fast(tck_too_fast));

// >>> tap_ctl_model.sv
`timescale 1ns/10ps
module tap_ctl_model (
    input  wire clk_sys,
    output reg  test_port_reset_n,
    output reg  test_port_clock,
    output reg  test_port_mode_select,
    output reg  test_port_serial_in,
    input  wire test_port_serial_out,
    input  wire test_port_serial_out_en
);
    integer half;  // Sys cycles per half period
    reg     tdo_r; // Last value step returned for the serial out pin
    initial
    begin
        half = 5;
        tdo_r = 1'b0;
        test_port_reset_n = 1'b1;
        test_port_clock = 1'b0;
        test_port_mode_select = 1'b1;
        test_port_serial_in = 1'b1;
    end
    // One test clock period; the clock stands low between calls
    task step(input tms, input tdi, output tdo);
    begin
        @(negedge clk_sys);
        test_port_mode_select = tms;
        test_port_serial_in = tdi;
        repeat (half) @(negedge clk_sys);
        test_port_clock = 1'b1;
        // A released pin reads back inverted, never as a stale level
        tdo = test_port_serial_out_en ? test_port_serial_out : ~tdo_r;
        tdo_r = tdo;
        repeat (half) @(negedge clk_sys);
        test_port_clock = 1'b0;
    end
    endtask
endmodule

// >>> tap_port_test.sv
`timescale 1ns/10ps
`include "tap_regs.vh"
module tap_port_test;
    reg        clk_sys;
    reg        resetn;
    wire       trst_n, tck, tms, tdi, tdo, tdo_en, too_fast;
    wire [3:0] state;
    wire [3:0] instr;
    integer    errors, checked, cycles;
    reg        b;
    tap_port dut (.clk_sys(clk_sys), .resetn(resetn),
        .test_port_reset_n(trst_n), .test_port_clock(tck),
        .test_port_mode_select(tms), .test_port_serial_in(tdi),
        .test_port_serial_out(tdo), .test_port_serial_out_en(tdo_en),
        .tap_state(state), .tap_instr(instr), .tck_too_fast(too_fast));
    tap_ctl_model ctl (.clk_sys(clk_sys), .test_port_reset_n(trst_n),
        .test_port_clock(tck), .test_port_mode_select(tms),
        .test_port_serial_in(tdi), .test_port_serial_out(tdo),
        .test_port_serial_out_en(tdo_en));
    task check(input [31:0] seen, input [31:0] exp);
    begin
        checked = checked + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task give_verdict;
    begin
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    // Load an instruction from reset or idle; capture comes out LSB first
    task ir_scan(input [3:0] code);
        reg [3:0] cap;
        integer   i;
    begin
        ctl.step(0, 1, b);
        ctl.step(1, 1, b);
        ctl.step(1, 1, b);
        ctl.step(0, 1, b);
        ctl.step(0, 1, b);
        check(state, `TAP_ST_SHIFT_IR);
        for (i = 0; i < 4; i = i + 1)
        begin
            ctl.step(i == 3, code[i], b);
            cap[i] = b;
        end
        check(cap, `TAP_IR_CAPTURE);
        ctl.step(1, 1, b);
        ctl.step(0, 1, b);
        check(instr, code);
        check(state, `TAP_ST_IDLE);
        check(tdo_en, 0);
    end
    endtask
    // Data scan of len bits; the last eight bits out are compared.
    // Bypass returns the pattern one clock late, the wide path 32 late.
    task dr_scan(input [7:0] pat, input integer len, input [7:0] exp);
        reg [7:0] got;
        integer   i;
    begin
        ctl.step(0, 0, b);
        ctl.step(1, 0, b);
        ctl.step(0, 0, b);
        ctl.step(0, 0, b);
        check(state, `TAP_ST_SHIFT_DR);
        got = 8'h00;
        for (i = 0; i < len; i = i + 1)
        begin
            ctl.step(i == len - 1, (i < 8) ? pat[i] : 1'b0, b);
            if (i >= len - 8)
                got[i - (len - 8)] = b;
        end
        check(got, exp);
        ctl.step(1, 0, b);
        ctl.step(0, 0, b);
        check(state, `TAP_ST_IDLE);
        check(tdo_en, 0);
    end
    endtask
    // Test reset in mid-shift with the test clock standing still
    task trst_mid_shift;
    begin
        ctl.step(1, 1, b);
        ctl.step(1, 1, b);
        ctl.step(0, 1, b);
        ctl.step(0, 1, b);
        repeat (4) @(negedge clk_sys);
        check(tdo_en, 1);
        ctl.test_port_reset_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        check(state, `TAP_ST_RESET);
        check(instr, `TAP_IR_RESET);
        check(tdo_en, 0);
        ctl.test_port_reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
    end
    endtask
    // Five mode-select ones reach reset from any state
    task tms_reset;
        integer i;
    begin
        for (i = 0; i < 5; i = i + 1)
            ctl.step(1, 0, b);
        check(state, `TAP_ST_RESET);
        check(instr, `TAP_IR_RESET);
    end
    endtask
    // A burst of four-cycle high phases breaks the clock limit
    task too_fast_clock;
    begin
        check(too_fast, 0);
        ctl.half = 4;
        repeat (3) ctl.step(0, 0, b);
        ctl.half = 5;
        check(too_fast, 1);
    end
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Cuts a hang short; the tests need about eleven hundred cycles
    always @(posedge clk_sys)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            errors = errors + 1;
            give_verdict;
        end
    end
    initial
    begin
        errors = 0;
        checked = 0;
        cycles = 0;
        resetn = 1'b0;
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
        check(state, `TAP_ST_RESET);
        check(instr, `TAP_IR_RESET);
        check(tdo_en, 0);
        ir_scan(4'h5);
        trst_mid_shift;
        ir_scan(4'ha);
        dr_scan(8'hc3, 40, 8'hc3);
        tms_reset;
        dr_scan(8'hb5, 8, 8'h6a);
        too_fast_clock;
        give_verdict;
    end
endmodule
